/* File: logic/rcc_pkg.sv */
// Purpose: shared constants of the calendar counter block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   every offset, field and reset value is named here once
package rcc_pkg;

  localparam int ADDR_W = 6;   // register window address width
  localparam int DATA_W = 32;  // bus data width

  // register byte offsets
  localparam logic [5:0] OFF_CTRL   = 6'h00;  // source, prescale, compensation
  localparam logic [5:0] OFF_MOD    = 6'h04;  // tick_modulo
  localparam logic [5:0] OFF_CNT    = 6'h08;  // tick_counter, read only
  localparam logic [5:0] OFF_SEC    = 6'h0c;  // seconds_count
  localparam logic [5:0] OFF_MIN    = 6'h10;  // minutes_count
  localparam logic [5:0] OFF_HR     = 6'h14;  // hours_count
  localparam logic [5:0] OFF_STAT   = 6'h18;  // sticky events, read only
  localparam logic [5:0] OFF_CLR    = 6'h1c;  // write one to clear, write only
  localparam logic [5:0] OFF_INTEN  = 6'h20;  // interrupt enable

  // control field positions
  localparam int CTRL_SRC_LO   = 0;   // source_select_field [1:0]
  localparam int CTRL_PS_LO    = 4;   // fast_osc_prescale_field [7:4]
  localparam int CTRL_CEN_BIT  = 8;   // compensation enable
  localparam int CTRL_CCS_LO   = 9;   // compensation period [10:9]
  localparam int CTRL_Q_LO     = 16;  // extra counts [23:16]

  // event bit positions in status, clear and enable
  localparam int EV_SEC  = 0;
  localparam int EV_MIN  = 1;
  localparam int EV_HR   = 2;
  localparam int EV_4HZ  = 3;
  localparam int EV_N    = 4;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0031;  // watch crystal, prescale 3
  localparam logic [15:0] MOD_RST  = 16'h8000;       // 32768 counts

  // calendar limits
  localparam logic [5:0] SEC_MAX = 6'h3b;  // 59
  localparam logic [5:0] MIN_MAX = 6'h3b;  // 59
  localparam logic [4:0] HR_MAX  = 5'h17;  // 23

  // fixed divider last count, divide by 32
  localparam logic [4:0] DIV32_LAST = 5'h1f;

  // compensation periods in seconds, last second index
  localparam logic [5:0] CCS_LAST_5  = 6'h04;
  localparam logic [5:0] CCS_LAST_15 = 6'h0e;
  localparam logic [5:0] CCS_LAST_30 = 6'h1d;
  localparam logic [5:0] CCS_LAST_60 = 6'h3b;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // counter source selection
  typedef enum logic [1:0] {
    SRC_MAIN  = 2'b00,
    SRC_WATCH = 2'b01,
    SRC_RC    = 2'b10,
    SRC_NONE  = 2'b11
  } rcc_src_type;

endpackage : rcc_pkg

/* File: logic/rcc_top.sv */
// Purpose: real-time calendar counter with prescaler and AXI4-Lite registers
// Assumes: source clocks are far slower than aclk and are sampled as pins
// Notes:   all logic runs on aclk; source edges become one-cycle enables
`timescale 1ns/1ns
module rcc_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       main_osc_clock,
  input  wire logic                       watch_crystal_clock,
  input  wire logic                       internal_rc_clock,
  input  wire logic                       stop_mode,
  input  wire logic [rcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [rcc_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [rcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [rcc_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic                            irq
);
  import rcc_pkg::*;
  // pin sampling: three source clocks and the stop request
  logic [3:0]  pin_raw;      // pins gathered
  logic [3:0]  sync1_q;      // first stage, read only by second
  logic [3:0]  sync2_q;      // second stage
  logic [2:0]  prev_q;       // delayed second stage, for edges
  logic [2:0]  rise;         // rising edge per source
  // registers
  logic [31:0] ctrl_q;       // control word
  logic [15:0] mod_q;        // tick_modulo
  logic [EV_N-1:0] stat_q;   // sticky events
  logic [EV_N-1:0] inten_q;  // interrupt enables
  // dividers and counters
  logic [3:0]  ps_cnt_q;     // prescale counter
  logic [4:0]  div32_q;      // fixed divider
  logic [16:0] tick_cnt_q;   // tick_counter, spare msb for extension
  logic [5:0]  comp_sec_q;   // second index in compensation period
  logic [5:0]  sec_q;        // seconds_count
  logic [5:0]  min_q;        // minutes_count
  logic [4:0]  hr_q;         // hours_count
  // control fields
  rcc_src_type src;          // source_select_field
  logic [3:0]  ps_field;     // fast_osc_prescale_field
  logic        comp_en;      // compensation enable
  logic [1:0]  ccs;          // compensation period select
  logic [7:0]  q_extra;      // extra counts in last second
  // derived pulses and values
  logic        stopped;      // main source halted by stop
  logic        mhz_pulse;    // prescaler output step
  logic        div_in;       // fixed divider input step
  logic        div_out;      // fixed divider output step
  logic        cnt_step;     // counter_input_clock step
  logic [5:0]  ccs_last;     // last second index of period
  logic        last_sec;     // current second is extended
  logic [16:0] limit;        // wrap value this second
  logic [16:0] cnt_next;     // tick counter plus one
  logic [16:0] quarter;      // a quarter of modulo
  logic        sec_tick;     // one-second tick
  logic        min_tick;     // minute carry
  logic        hr_tick;      // hour carry
  logic        qtr_tick;     // 4 Hz event
  logic [EV_N-1:0] ev;       // events this cycle
  // bus
  logic        aw_have_q;    // write address held
  logic        w_have_q;     // write data held
  logic [5:0]  aw_q;         // held write address
  logic [31:0] w_q;          // held write data
  logic [3:0]  ws_q;         // held strobes
  logic        wr_fire;      // perform the held write
  logic        wr_ok;        // held address is writable
  logic [31:0] wr_val;       // strobe-merged write value
  logic [31:0] old_val;      // current value at write address
  logic [31:0] rd_val;       // read mux output
  logic        rd_ok;        // read address is mapped
  assign pin_raw = {stop_mode, internal_rc_clock, watch_crystal_clock, main_osc_clock};
  // two-flop synchronisers, shared reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 3'h0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q[2:0];
    end
  end
  // edge detect per source clock
  for (genvar gi = 0; gi < 3; gi++) begin : g_edge
    assign rise[gi] = sync2_q[gi] & ~prev_q[gi];
  end
  // control field split
  assign src      = rcc_src_type'(ctrl_q[CTRL_SRC_LO +: 2]);
  assign ps_field = ctrl_q[CTRL_PS_LO +: 4];
  assign comp_en  = ctrl_q[CTRL_CEN_BIT];
  assign ccs      = ctrl_q[CTRL_CCS_LO +: 2];
  assign q_extra  = ctrl_q[CTRL_Q_LO +: 8];
  // main oscillator halts in stop; crystal and rc keep running
  assign stopped   = (src == SRC_MAIN) && sync2_q[3];
  assign mhz_pulse = rise[0] && !stopped && (ps_cnt_q == ps_field);
  // programmable prescaler, divides main clock by field plus one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_cnt_q <= 4'h0;
    end else if (src != SRC_MAIN) begin
      ps_cnt_q <= 4'h0;
    end else if (rise[0] && !stopped) begin
      ps_cnt_q <= mhz_pulse ? 4'h0 : ps_cnt_q + 4'h1;
    end
  end
  // fixed divide-by-32 input selection
  always_comb begin
    case (src)
      SRC_MAIN: div_in = mhz_pulse;
      SRC_RC:   div_in = rise[2];
      default:  div_in = 1'b0;
    endcase
  end
  assign div_out = div_in && (div32_q == DIV32_LAST);
  // fixed divide-by-32 stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div32_q <= 5'h00;
    end else if (div_in) begin
      div32_q <= div32_q + 5'h01;
    end
  end
  // counter clock source mux
  always_comb begin
    case (src)
      SRC_WATCH: cnt_step = rise[1];
      SRC_MAIN:  cnt_step = div_out;
      SRC_RC:    cnt_step = div_out;
      default:   cnt_step = 1'b0;
    endcase
  end
  // compensation period and extended last second
  always_comb begin
    case (ccs)
      2'b00:   ccs_last = CCS_LAST_5;
      2'b01:   ccs_last = CCS_LAST_15;
      2'b10:   ccs_last = CCS_LAST_30;
      default: ccs_last = CCS_LAST_60;
    endcase
  end
  assign last_sec = comp_en && (comp_sec_q >= ccs_last);
  assign limit    = {1'b0, mod_q} + (last_sec ? {9'h000, q_extra} : 17'h00000);
  assign cnt_next = tick_cnt_q + 17'h00001;
  assign sec_tick = cnt_step && (cnt_next >= limit);
  assign min_tick = sec_tick && (sec_q == SEC_MAX);
  assign hr_tick  = min_tick && (min_q == MIN_MAX);
  // 4 Hz event at each quarter of the modulo and at the wrap
  assign quarter  = {3'h0, mod_q[15:2]};
  assign qtr_tick = sec_tick || (cnt_step && (quarter != 17'h00000) &&
                    ((cnt_next == quarter) || (cnt_next == (quarter << 1)) ||
                     (cnt_next == (quarter << 1) + quarter)));
  // tick counter, restarts from zero on wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 17'h00000;
    end else if (sec_tick) begin
      tick_cnt_q <= 17'h00000;
    end else if (cnt_step) begin
      tick_cnt_q <= cnt_next;
    end
  end
  // second index within compensation period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_sec_q <= 6'h00;
    end else if (!comp_en) begin
      comp_sec_q <= 6'h00;
    end else if (sec_tick) begin
      comp_sec_q <= last_sec ? 6'h00 : comp_sec_q + 6'h01;
    end
  end
  // write handshake: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_q      <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_q      <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_q      <= 32'h0000_0000;
      ws_q     <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_q      <= s_axi_wdata;
      ws_q     <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end
  // write decode: current value for strobe merge
  always_comb begin
    wr_ok   = 1'b1;
    old_val = 32'h0000_0000;
    if (aw_q == OFF_CTRL) begin
      old_val = ctrl_q;
    end else if (aw_q == OFF_MOD) begin
      old_val = {16'h0000, mod_q};
    end else if (aw_q == OFF_SEC) begin
      old_val = {26'h0000000, sec_q};
    end else if (aw_q == OFF_MIN) begin
      old_val = {26'h0000000, min_q};
    end else if (aw_q == OFF_HR) begin
      old_val = {27'h0000000, hr_q};
    end else if (aw_q == OFF_CLR) begin
      old_val = 32'h0000_0000;
    end else if (aw_q == OFF_INTEN) begin
      old_val = {28'h0000000, inten_q};
    end else begin
      wr_ok = 1'b0;                                  // unmapped or read only
    end
  end
  // byte lanes merged with the current value
  for (genvar gi = 0; gi < 4; gi++) begin : g_strb
    assign wr_val[gi*8 +: 8] = ws_q[gi] ? w_q[gi*8 +: 8] : old_val[gi*8 +: 8];
  end
  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // control, modulo and interrupt enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= CTRL_RST;
      mod_q   <= MOD_RST;
      inten_q <= '0;
    end else if (wr_fire) begin
      if (aw_q == OFF_CTRL) begin
        ctrl_q <= wr_val;
      end else if (aw_q == OFF_MOD) begin
        mod_q <= wr_val[15:0];
      end else if (aw_q == OFF_INTEN) begin
        inten_q <= wr_val[EV_N-1:0];
      end
    end
  end
  // calendar counters; a software write takes priority over a step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_q <= 6'h00;
      min_q <= 6'h00;
      hr_q  <= 5'h00;
    end else begin
      if (wr_fire && aw_q == OFF_SEC) begin
        sec_q <= wr_val[5:0];
      end else if (min_tick) begin
        sec_q <= 6'h00;
      end else if (sec_tick) begin
        sec_q <= sec_q + 6'h01;
      end
      if (wr_fire && aw_q == OFF_MIN) begin
        min_q <= wr_val[5:0];
      end else if (hr_tick) begin
        min_q <= 6'h00;
      end else if (min_tick) begin
        min_q <= min_q + 6'h01;
      end
      if (wr_fire && aw_q == OFF_HR) begin
        hr_q <= wr_val[4:0];
      end else if (hr_tick) begin
        hr_q <= (hr_q >= HR_MAX) ? 5'h00 : hr_q + 5'h01;
      end
    end
  end
  // sticky events; a new event wins over a clear in the same cycle
  assign ev = {qtr_tick, hr_tick, min_tick, sec_tick};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else if (wr_fire && aw_q == OFF_CLR) begin
      stat_q <= (stat_q & ~wr_val[EV_N-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end
  assign irq = |(stat_q & inten_q);
  // read decode
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == OFF_CTRL) begin
      rd_val = ctrl_q;
    end else if (s_axi_araddr == OFF_MOD) begin
      rd_val = {16'h0000, mod_q};
    end else if (s_axi_araddr == OFF_CNT) begin
      rd_val = {16'h0000, tick_cnt_q[15:0]};
    end else if (s_axi_araddr == OFF_SEC) begin
      rd_val = {26'h0000000, sec_q};
    end else if (s_axi_araddr == OFF_MIN) begin
      rd_val = {26'h0000000, min_q};
    end else if (s_axi_araddr == OFF_HR) begin
      rd_val = {27'h0000000, hr_q};
    end else if (s_axi_araddr == OFF_STAT) begin
      rd_val = {28'h0000000, stat_q};
    end else if (s_axi_araddr == OFF_CLR) begin
      rd_val = 32'h0000_0000;                        // write only, reads zero
    end else if (s_axi_araddr == OFF_INTEN) begin
      rd_val = {28'h0000000, inten_q};
    end else begin
      rd_ok = 1'b0;                                  // unmapped
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  // read data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : rcc_top

/* File: bench/rcc_checker.sv */
// Purpose: port checks for the calendar counter register bus and irq
// Assumes: one aclk domain, synchronous active low reset
// Notes:   bound to rcc_top from the bench top file
`timescale 1ns/1ns
module rcc_checker (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [rcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [rcc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic                       irq
);
  import rcc_pkg::*;
  // every check on the bus clock, quiet in reset except the reset idle check
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // write response held until taken
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  // response gone after the taking edge
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  // read data held until taken
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before rready");
  // read answered one cycle after address
  chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // no new read while one is pending
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  // no write halves taken while response pending
  chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  // unmapped reads give error and zero data
  chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h23
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // mapped aligned reads are accepted
  chk_mapped_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 6'h20
    && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  // reset leaves outputs idle and ready
  chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !irq && s_axi_arready)
    else $error("outputs busy after reset");
  // main scenarios reached
  cov_write_done: cover property (s_axi_bvalid && s_axi_bready);
  cov_read_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cov_irq_rise: cover property ($rose(irq));
endmodule : rcc_checker

/* File: bench/rcc_top_test.sv */
// Purpose: self-checking bench for the calendar counter
// Assumes: source pins are slow pulses driven by the bench
// Notes:   register table first, then counting, irq and reset cases
`timescale 1ns/1ns
module rcc_top_test;
  import rcc_pkg::*;
  typedef struct packed {
    logic        wr;  // write row
    logic [5:0]  a;   // byte offset
    logic [31:0] d;   // data written or expected
    logic [1:0]  r;   // expected response
  } rcc_row_type;
  logic        aclk, aresetn, stop_mode;    // clock, reset, stop level
  logic [2:0]  pin;                         // main, watch, rc pins
  logic [5:0]  s_axi_awaddr, s_axi_araddr;  // bus addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;    // bus data
  logic [3:0]  s_axi_wstrb;                 // byte lanes
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;    // responses
  wire         main_osc_clock      = pin[0];
  wire         watch_crystal_clock = pin[1];
  wire         internal_rc_clock   = pin[2];
  int          error_cnt, comparisons;      // mismatches, compares
  logic [31:0] c0, s0, x;                   // saved count, seconds, scratch
  logic [1:0]  rs;                          // scratch response
  // register cases: reset values, refusals, plain access
  rcc_row_type rows [14] = '{
    '{1'b0, OFF_CTRL, CTRL_RST, RESP_OKAY}, '{1'b0, OFF_MOD, 32'h8000, RESP_OKAY},
    '{1'b0, OFF_CNT, 32'h0, RESP_OKAY}, '{1'b0, OFF_SEC, 32'h0, RESP_OKAY},
    '{1'b0, OFF_MIN, 32'h0, RESP_OKAY}, '{1'b0, OFF_HR, 32'h0, RESP_OKAY},
    '{1'b0, OFF_STAT, 32'h0, RESP_OKAY}, '{1'b0, OFF_INTEN, 32'h0, RESP_OKAY},
    '{1'b0, OFF_CLR, 32'h0, RESP_OKAY}, '{1'b0, 6'h24, 32'h0, RESP_SLVERR},
    '{1'b1, OFF_CNT, 32'h5, RESP_SLVERR}, '{1'b1, OFF_STAT, 32'hf, RESP_SLVERR},
    '{1'b1, OFF_SEC, 32'h2a, RESP_OKAY}, '{1'b0, OFF_SEC, 32'h2a, RESP_OKAY}};
  rcc_top rcc_top_inst (.*);
  // 100 ns bus clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // word compare, counted
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t word %h expected %h", $time, g, e);
    end
  endtask : chk_word
  // single bit compare, counted
  task automatic chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
    end
  endtask : chk_bit
  // one bus transfer; ready sampled at the settled mid-cycle
  // response ready comes late so a held bvalid or rvalid is exercised
  task automatic bus(input logic w, input logic [5:0] a, inout logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw, tr, td;
    int   n;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
    end
    td = 1'b0;
    for (n = 0; n < 50 && !td; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      td = w ? (s_axi_bvalid && s_axi_bready) : (s_axi_rvalid && s_axi_rready);
      r  = w ? s_axi_bresp : s_axi_rresp;
      if (!w) d = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (n == 2) begin
        s_axi_bready <= w;
        s_axi_rready <= !w;
      end
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk_bit(td, 1'b1);
  endtask : bus
  // write expecting acceptance
  task automatic wok(input logic [5:0] a, input logic [31:0] d);
    x = d;
    bus(1'b1, a, x, rs);
    chk_word({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask : wok
  // read and compare
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, x, rs);
    chk_word(x, e);
    chk_word({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask : rchk
  // irq level, away from the clock edge
  task automatic chk_irq(input logic e);
    @(negedge aclk);
    chk_bit(irq, e);
  endtask : chk_irq
  // n slow pulses on one source pin
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge aclk);
      pin[which] <= 1'b1;
      repeat (4) @(posedge aclk);
      pin[which] <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask : pulse
  // pin pulses between two counter steps, after aligning once
  task automatic meas(input int which, input int e);
    logic [31:0] c;
    int          n;
    bus(1'b0, OFF_CNT, c, rs);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      x = c;
      while (x === c && n < 100) begin
        pulse(which, 1);
        bus(1'b0, OFF_CNT, x, rs);
        n++;
      end
      c = x;
    end
    chk_word(32'(n), 32'(e));
  endtask : meas
  // counts, verdict and end of run
  task automatic give_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // hang guard, far past the few thousand cycles expected
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end
  // main sequence
  initial begin
    error_cnt = 0;
    comparisons = 0;
    aresetn = 1'b0;
    stop_mode = 1'b0;
    pin = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // table of register cases
    foreach (rows[i]) begin
      x = rows[i].d;
      bus(rows[i].wr, rows[i].a, x, rs);
      if (!rows[i].wr) chk_word(x, rows[i].d);
      chk_word({30'h0, rs}, {30'h0, rows[i].r});
    end
    // watch crystal, modulo 3: steps, wrap, one second each wrap
    wok(OFF_MOD, 32'h3);
    pulse(1, 1);
    bus(1'b0, OFF_CNT, c0, rs);
    bus(1'b0, OFF_SEC, s0, rs);
    pulse(1, 1);
    rchk(OFF_CNT, (c0 + 32'h1) % 32'h3);
    pulse(1, 2);
    rchk(OFF_CNT, c0);
    rchk(OFF_SEC, s0 + 32'h1);
    // stop mode must not halt the crystal source
    stop_mode <= 1'b1;
    pulse(1, 3);
    rchk(OFF_SEC, s0 + 32'h2);
    // full calendar rollover in one tick, events and irq
    wok(OFF_MOD, 32'h1);
    wok(OFF_SEC, 32'h3b);
    wok(OFF_MIN, 32'h3b);
    wok(OFF_HR, 32'h17);
    wok(OFF_CLR, 32'hf);
    wok(OFF_INTEN, 32'h1);
    chk_irq(1'b0);
    pulse(1, 1);
    rchk(OFF_SEC, 32'h0);
    rchk(OFF_MIN, 32'h0);
    rchk(OFF_HR, 32'h0);
    rchk(OFF_STAT, 32'hf);
    chk_irq(1'b1);
    wok(OFF_INTEN, 32'h0);
    chk_irq(1'b0);
    wok(OFF_INTEN, 32'hf);
    wok(OFF_CLR, 32'h1);
    rchk(OFF_STAT, 32'he);
    chk_irq(1'b1);
    // rc source through the fixed divider only
    stop_mode <= 1'b0;
    wok(OFF_MOD, 32'h100);
    wok(OFF_CTRL, {30'h0, SRC_RC});
    meas(2, 32);
    // main source, prescale field 1: divide by 2 then by 32
    wok(OFF_CTRL, 32'h10);
    meas(0, 64);
    // main source frozen in stop mode
    stop_mode <= 1'b1;
    bus(1'b0, OFF_CNT, c0, rs);
    pulse(0, 70);
    rchk(OFF_CNT, c0);
    // reset in mid-run restores defaults and drops irq
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFF_CTRL, CTRL_RST);
    rchk(OFF_SEC, 32'h0);
    chk_irq(1'b0);
    // compensation: every fifth second of modulo 2 takes one extra step
    wok(OFF_MOD, 32'h2);
    wok(OFF_CTRL, 32'h0001_0101);
    pulse(1, 10);
    rchk(OFF_SEC, 32'h4);
    rchk(OFF_CNT, 32'h2);
    pulse(1, 1);
    rchk(OFF_SEC, 32'h5);
    rchk(OFF_CNT, 32'h0);
    // settings software uses for one-second ticks from the main osc
    wok(OFF_MOD, 32'h7a12);
    rchk(OFF_MOD, 32'h7a12);
    wok(OFF_CTRL, 32'h30);
    rchk(OFF_CTRL, 32'h30);
    give_verdict();
  end
endmodule : rcc_top_test
bind rcc_top rcc_checker rcc_checker_inst (.*);
